//--- logic/port_pins_defines.svh
// constants for the shared-function port pins: addresses, reset values
`ifndef PORT_PINS_DEFINES_SVH
`define PORT_PINS_DEFINES_SVH

// ----------------------------------------------------------------
// port addresses for output and input instructions
// ----------------------------------------------------------------
`define ADDR_FIRST_PORT 5'h04
`define ADDR_SECOND_PORT 5'h05

// ----------------------------------------------------------------
// latch reset values and fixed read bits
// ----------------------------------------------------------------
`define FIRST_LATCH_RESET 3'h7
`define SECOND_LATCH_RESET 4'hF
`define READ_ONE 1'h1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define FIRST_BAR_BIT 2
`define SECOND_OSC_OUT_BIT 3
`define SECOND_OSC_IN_BIT 2
`define SECOND_SYNC_BIT 1
`define SECOND_BAR_BIT 0

`endif

//--- logic/port_pins_pkg.sv
// types shared by the shared-function port pins block
package port_pins_pkg;

	// port access from the core: one instruction per strobe
	typedef struct packed {
		logic wr;        // output instruction strobe
		logic rd;        // input instruction strobe
		logic [4:0] addr; // port address
		logic [3:0] data; // write data
	} io_req_s;

	// one group of open-drain / push-pull pin drivers
	typedef struct packed {
		logic [3:0] out; // driven level
		logic [3:0] oe;  // high while driving
	} pin_drive_s;

endpackage

//--- logic/shared_function_port_pins.sv
// two latched shared-function i/o ports with bar, resonator and sync uses
`timescale 1ns/1ns
`include "port_pins_defines.svh"

module shared_function_port_pins (
	input wire logic clk, // core clock, 50 MHz
	input wire logic rst, // synchronous reset, active high
	input wire port_pins_pkg::io_req_s io_req, // port instruction
	output logic [3:0] io_rdata, // input instruction data
	output logic io_rvalid, // read data valid pulse
	input wire logic [2:0] first_pin_in, // first port pin levels
	output logic [2:0] first_pin_out, // first port drive level
	output logic [2:0] first_pin_oe, // first port drive enable
	input wire logic [3:0] second_pin_in, // second port pin levels
	output port_pins_pkg::pin_drive_s second_pin, // second port drivers
	input wire logic overlay_master_enable, // overlay on
	input wire logic bar_output_0_select, // bar 0 routed to pin
	input wire logic bar_output_1_select, // bar 1 routed to pin
	input wire logic bar_output_0, // bar 0 video from engine
	input wire logic bar_output_1, // bar 1 video from engine
	input wire logic resonator_drive, // resonator amplifier output
	output logic overlay_resonator_in, // resonator pin level to engine
	output logic line_sync_in // horizontal sync level to counter
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	logic [2:0] first_q;
	logic [3:0] second_q;
	logic [2:0] first_out_d, first_oe_d;
	port_pins_pkg::pin_drive_s second_d;
	logic [3:0] rdata_d;

	// open-drain plain pin: released while latch is one
	function automatic logic od_enable(input logic latch);
		od_enable = ~latch;
	endfunction

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	wire hit_first = io_req.addr == `ADDR_FIRST_PORT;
	wire hit_second = io_req.addr == `ADDR_SECOND_PORT;
	wire wr_first = io_req.wr & hit_first;
	wire wr_second = io_req.wr & hit_second;
	wire rd_any = io_req.rd & (hit_first | hit_second);
	// selects count only under the master enable
	wire bar0_on = overlay_master_enable & bar_output_0_select;
	wire bar1_on = overlay_master_enable & bar_output_1_select;
	wire osc_on = overlay_master_enable;

	// port latches; reset sets every bit so pins come up released
	always_ff @(posedge clk) begin
		if (rst) begin
			first_q <= `FIRST_LATCH_RESET;
			second_q <= `SECOND_LATCH_RESET;
		end else begin
			if (wr_first) begin
				first_q <= io_req.data[2:0];
			end
			if (wr_second) begin
				second_q <= io_req.data;
			end
		end
	end

	// first port drivers; bar video gated by the latch for bar height
	always_comb begin
		first_out_d = 3'h0;
		first_oe_d[1:0] = {od_enable(first_q[1]), od_enable(first_q[0])};
		first_oe_d[2] = od_enable(first_q[2]);
		if (bar0_on) begin
			first_out_d[2] = bar_output_0 & first_q[2];
			first_oe_d[2] = 1'h1;
		end
	end

	// second port drivers: resonator pair, sync input, bar 1
	always_comb begin
		second_d.out = 4'h0;
		second_d.oe = ~second_q;
		if (osc_on) begin
			// latches must stay one here, so they are not consulted
			second_d.out[3] = resonator_drive;
			second_d.oe[3] = 1'h1;
			second_d.oe[2] = 1'h0;
		end
		if (bar1_on) begin
			second_d.out[0] = bar_output_1 & second_q[0];
			second_d.oe[0] = 1'h1;
		end
	end

	// read data mux; fixed ones mask pins lent to the overlay
	always_comb begin
		if (hit_first) begin
			rdata_d = {`READ_ONE, first_pin_in};
			if (bar0_on) begin
				rdata_d[`FIRST_BAR_BIT] = `READ_ONE;
			end
		end else if (osc_on) begin
			rdata_d = {2'h3, second_pin_in[1], 1'h1};
		end else begin
			rdata_d = second_pin_in;
		end
	end

	// registered outputs; one cycle from latch change to pin
	always_ff @(posedge clk) begin
		if (rst) begin
			first_pin_out <= 3'h0;
			first_pin_oe <= 3'h0;
			second_pin <= '0;
			io_rdata <= 4'h0;
			io_rvalid <= 1'h0;
			overlay_resonator_in <= 1'h0;
			line_sync_in <= 1'h0;
		end else begin
			first_pin_out <= first_out_d;
			first_pin_oe <= first_oe_d;
			second_pin <= second_d;
			io_rvalid <= rd_any;
			if (rd_any) begin
				io_rdata <= rdata_d;
			end
			overlay_resonator_in <= second_pin_in[`SECOND_OSC_IN_BIT];
			line_sync_in <= second_pin_in[`SECOND_SYNC_BIT];
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	latch_reset_a: assert property (@(posedge clk)
		$past(rst) && !rst
		|-> first_q == `FIRST_LATCH_RESET && second_q == `SECOND_LATCH_RESET)
		else $error("latches not one after reset");
	bar0_pin_a: assert property (@(posedge clk) disable iff (rst)
		bar0_on |=> first_pin_oe[2]
		&& first_pin_out[2] == $past(bar_output_0 & first_q[2]))
		else $error("bar 0 not on first bit 2");
	bar0_read_a: assert property (@(posedge clk) disable iff (rst)
		io_req.rd && hit_first && bar0_on |=> io_rdata[2])
		else $error("bar 0 pin read not one");
	bit3_read_a: assert property (@(posedge clk) disable iff (rst)
		io_req.rd && hit_first |=> io_rvalid && io_rdata[3])
		else $error("first bit 3 read not one");
	osc_pins_a: assert property (@(posedge clk) disable iff (rst)
		osc_on |=> second_pin.oe[3:2] == 2'h2)
		else $error("resonator pins wrong");
	bar1_pin_a: assert property (@(posedge clk) disable iff (rst)
		bar1_on && !bar_output_1 |=> second_pin.oe[0] && !second_pin.out[0])
		else $error("bar 1 not on second bit 0");
	second_read_a: assert property (@(posedge clk) disable iff (rst)
		io_req.rd && hit_second && osc_on
		|=> io_rdata == {2'h3, $past(second_pin_in[1]), 1'h1})
		else $error("overlay read of second port wrong");
	write_first_a: assert property (@(posedge clk) disable iff (rst)
		wr_first ##1 !bar0_on |=> first_pin_oe == ~$past(first_q))
		else $error("write at first port address lost");
	plain_pin_a: assert property (@(posedge clk) disable iff (rst)
		!osc_on && !bar1_on |=> second_pin.oe == ~$past(second_q)
		&& second_pin.out == 4'h0)
		else $error("plain pin drive wrong");

	// ------------------------------------------------------------
	// checks on latches, plain reads, refused addresses and overlay pins
	// ------------------------------------------------------------
	// a stray strobe must never disturb the first latch
	latch_hold_a: assert property (
		@(posedge clk) disable iff (rst)
		!wr_first |=> first_q == $past(first_q))
		else $error("first latch moved without a write");
	// all four second-port bits are written, none masked
	second_write_a: assert property (
		@(posedge clk) disable iff (rst)
		wr_second |=> second_q == $past(io_req.data))
		else $error("second latch write lost");
	// select cleared: bit 2 falls back to the open-drain latch
	bar0_off_a: assert property (
		@(posedge clk) disable iff (rst)
		!bar0_on |=> first_pin_oe[2] == !$past(first_q[2]) && !first_pin_out[2])
		else $error("first bit 2 not plain with bar 0 off");
	// plain first-port read shows the live pins under the fixed bit 3
	first_read_a: assert property (
		@(posedge clk) disable iff (rst)
		io_req.rd && hit_first && !bar0_on
		|=> io_rdata == {`READ_ONE, $past(first_pin_in)})
		else $error("plain first port read wrong");
	// overlay off: nothing masks the second-port pins
	second_plain_a: assert property (
		@(posedge clk) disable iff (rst)
		io_req.rd && hit_second && !osc_on |=> io_rdata == $past(second_pin_in))
		else $error("plain second port read wrong");
	// unmapped addresses and idle cycles give no answer
	no_answer_a: assert property (
		@(posedge clk) disable iff (rst)
		!rd_any |=> !io_rvalid)
		else $error("read answer without a mapped read");
	// the amplifier owns bit 3 while the overlay runs
	osc_drive_a: assert property (
		@(posedge clk) disable iff (rst)
		osc_on |=> second_pin.out[3] == $past(resonator_drive))
		else $error("resonator drive not on second bit 3");
	// sync and resonator levels pass one cycle late to the engine
	sync_copy_a: assert property (
		@(posedge clk) disable iff (rst)
		osc_on |=> line_sync_in == $past(second_pin_in[`SECOND_SYNC_BIT])
		&& overlay_resonator_in == $past(second_pin_in[`SECOND_OSC_IN_BIT]))
		else $error("sync or resonator level not passed on");

endmodule

//--- testbench/far_side_model.sv
// far-side pin model: pull-ups and outside drivers on both ports
`timescale 1ns/1ns
module far_side_model (
	input wire logic [2:0] a_out, // first port drive level
	input wire logic [2:0] a_oe, // first port drive enable
	input wire port_pins_pkg::pin_drive_s b_drv, // second port drivers
	input wire logic [2:0] a_ext, // outside level, 1 = released
	input wire logic [3:0] b_ext, // outside sync, resonator, loads
	output logic [2:0] a_lvl, // first port wire level
	output logic [3:0] b_lvl // second port wire level
);
	// wired-and with pull-up: a released wire never keeps a stale value
	assign a_lvl = a_ext & (~a_oe | a_out);
	assign b_lvl = b_ext & (~b_drv.oe | b_drv.out);
endmodule

//--- testbench/shared_function_port_pins_tb.sv
// self-checking bench for the shared-function port pins
`timescale 1ns/1ns
module shared_function_port_pins_tb;
	logic clk = 0;
	logic rst = 1;
	port_pins_pkg::io_req_s io_req = '0;
	port_pins_pkg::pin_drive_s b_drv;
	logic [3:0] rdata, b_lvl, b_ext = 4'hF;
	logic [2:0] a_out, a_oe, a_lvl, a_ext = 3'h7;
	logic rvalid, res_in, sync_in;
	logic ome = 0, s0 = 0, s1 = 0, bar0 = 0, bar1 = 0, rdrv = 0;
	int err_total = 0, n_tests = 0, cyc = 0, la = 7, lb = 15;
	always #10 clk = ~clk;
	shared_function_port_pins dut_u (.clk(clk), .rst(rst), .io_req(io_req),
		.io_rdata(rdata), .io_rvalid(rvalid), .first_pin_in(a_lvl),
		.first_pin_out(a_out), .first_pin_oe(a_oe), .second_pin_in(b_lvl),
		.second_pin(b_drv), .overlay_master_enable(ome),
		.bar_output_0_select(s0), .bar_output_1_select(s1),
		.bar_output_0(bar0), .bar_output_1(bar1), .resonator_drive(rdrv),
		.overlay_resonator_in(res_in), .line_sync_in(sync_in));
	far_side_model far_u (.a_out(a_out), .a_oe(a_oe), .b_drv(b_drv),
		.a_ext(a_ext), .b_ext(b_ext), .a_lvl(a_lvl), .b_lvl(b_lvl));
	// -------------------------------------------------------------
	// checking and closing
	// -------------------------------------------------------------
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// hang guard: the whole run needs well under 2000 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			complete_run();
		end
	end
	// pins, then back-to-back reads of both ports and one unmapped address
	task automatic verify();
		logic b0, b1;
		logic [2:0] aoe, aef;
		logic [3:0] boe, bef, bw, ra, rb;
		b0 = ome & s0;
		b1 = ome & s1;
		aoe = ~3'(la);
		aef = 3'(la);
		aoe[2] = b0 | aoe[2];
		aef[2] = b0 ? bar0 & aef[2] : aef[2];
		boe = ome ? {2'h2, ~2'(lb)} : ~4'(lb);
		bef = ome ? {rdrv, 1'h1, 2'(lb)} : 4'(lb);
		boe[0] = b1 | boe[0];
		bef[0] = b1 ? bar1 & bef[0] : bef[0];
		bw = b_ext & bef;
		ra = {1'h1, b0 | (a_ext[2] & aef[2]), a_ext[1:0] & aef[1:0]};
		rb = ome ? {2'h3, bw[1], 1'h1} : bw;
		check("first pins", {a_oe, ~a_oe | a_out}, {aoe, aef});
		check("second pins", {b_drv.oe, ~b_drv.oe | b_drv.out},
			{boe, bef});
		check("sync res", {res_in, sync_in}, bw[2:1]);
		io_req.rd = 1;
		for (int k = 4; k < 7; k++) begin
			io_req.addr = 5'(k);
			@(posedge clk);
			#2;
			check("rvalid", rvalid, k < 6);
			if (k < 6)
				check("rdata", rdata, k == 4 ? ra : rb);
		end
		io_req.rd = 0;
	endtask
	initial begin
		void'($urandom(6850));
		repeat (20) @(posedge clk);
		#2;
		rst = 0;
		repeat (3) @(posedge clk);
		#2;
		verify();
		$display("test reset done");
		repeat (80) begin
			{ome, s0, s1, bar0, bar1, rdrv} = 6'($urandom);
			a_ext = 3'($urandom);
			b_ext = 4'($urandom);
			io_req.addr = 5'h04 + 5'($urandom_range(0, 2));
			io_req.data = 4'($urandom);
			io_req.wr = 1;
			la = io_req.addr == 5'h04 ? 32'(io_req.data[2:0]) : la;
			lb = io_req.addr == 5'h05 ? 32'(io_req.data) : lb;
			@(posedge clk);
			#2;
			io_req.wr = 0;
			repeat (3) @(posedge clk);
			#2;
			verify();
		end
		$display("test random done");
		// second reset with latches scattered: all must come back to one
		rst = 1;
		repeat (2) @(posedge clk);
		#2;
		rst = 0;
		la = 7;
		lb = 15;
		repeat (3) @(posedge clk);
		#2;
		verify();
		$display("test mid reset done");
		// resonator and sync use: latches written one, far side drives the pins
		{ome, s0, s1} = 3'h4;
		io_req.wr = 1;
		io_req.addr = 5'h04;
		io_req.data = 4'hF;
		@(posedge clk);
		#2;
		io_req.addr = 5'h05;
		@(posedge clk);
		#2;
		io_req.wr = 0;
		la = 7;
		lb = 15;
		repeat (8) begin
			a_ext = {1'h1, 2'($urandom)};
			b_ext = {2'h3, 1'($urandom), 1'h1};
			repeat (2) @(posedge clk);
			#2;
			verify();
		end
		$display("test far side done");
		complete_run();
	end
endmodule
